//--- logic/rcp_regs.svh
// register offsets, fields, reset values and timing counts of the remote control block
`ifndef RCP_REGS_SVH
`define RCP_REGS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define RCP_CLK_NS          5
`define RCP_QUAL_NS         100000
`define RCP_QUAL_CYC        ((`RCP_QUAL_NS + `RCP_CLK_NS - 1) / `RCP_CLK_NS)
`define RCP_REMOTE_RESP_NS  200000000
`define RCP_REMOTE_RESP_CYC (`RCP_REMOTE_RESP_NS / `RCP_CLK_NS)
`define RCP_TRIG_RESP_NS    500000
`define RCP_TRIG_RESP_CYC   (`RCP_TRIG_RESP_NS / `RCP_CLK_NS)
`define RCP_HALT_RESP_NS    100000
`define RCP_HALT_RESP_CYC   (`RCP_HALT_RESP_NS / `RCP_CLK_NS)

// ----------------------------------------
// offsets (word index on the 4-bit address)
// ----------------------------------------
`define RCP_ADDR_CTRL    4'h0
`define RCP_ADDR_CMD     4'h1
`define RCP_ADDR_STATUS  4'h2
`define RCP_ADDR_EVT     4'h3
`define RCP_ADDR_MASK    4'h4
`define RCP_ADDR_TRIGCFG 4'h5

// ----------------------------------------
// fields
// ----------------------------------------
`define RCP_CTRL_MODE_LSB   0
`define RCP_CTRL_INV_BIT    2
`define RCP_CMD_EN_BIT      0
`define RCP_CMD_DIS_BIT     1
`define RCP_CMD_LSET_BIT    2
`define RCP_CMD_LCLR_BIT    3
`define RCP_CMD_STEP_BIT    4
`define RCP_EVT_TRIG_BIT    0
`define RCP_EVT_STBY_BIT    1
`define RCP_EVT_HALT_BIT    2
`define RCP_EVT_PULSE_BIT   3
`define RCP_TCFG_COND_BIT   16

// ----------------------------------------
// reset values
// ----------------------------------------
`define RCP_MASK_RST    4'h0
`define RCP_WIDTH_RST   16'h00C8
`define RCP_SYNC_RST    3'h3

`endif

//--- logic/rcp_pkg.sv
// types shared by the remote control block
package rcp_pkg;

  typedef enum logic [1:0] {
    RMODE_FOLLOW  = 2'h0,
    RMODE_IGNORE  = 2'h1,
    RMODE_STANDBY = 2'h2
  } rcp_rmode_e;

  typedef enum logic [3:0] {
    ST_ON      = 4'h1,
    ST_OFF     = 4'h2,
    ST_STANDBY = 4'h4,
    ST_HALT    = 4'h8
  } rcp_state_e;

endpackage

//--- logic/rcp_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps

module rcp_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

//--- logic/rcp_hold_qual.sv
// low-hold qualifier: one pulse after the level stays low LIMIT cycles, re-armed by high
`timescale 1ns/100ps

module rcp_hold_qual #(
  parameter int LIMIT = 20000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic level,
  output logic      fire
);

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        fired;

  // saturating at LIMIT blocks a second pulse until the level goes high
  always_comb begin
    fire     = !level && (cnt == 16'(LIMIT - 1));
    next_cnt = cnt;
    if (level) begin
      next_cnt = 16'h0000;
    end else if (cnt != 16'(LIMIT)) begin
      next_cnt = cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fired <= 1'b0;
    end else begin
      fired <= level ? 1'b0 : (fired | fire);
    end
  end

  property p_qual_hold;
    @(posedge clk) disable iff (rst) fire |-> $past(!level) && !level;
  endproperty
  a_qual_hold: assert property (p_qual_hold) else $error("pulse without held low level");

  property p_qual_rearm;
    @(posedge clk) disable iff (rst) fire |-> !fired;
  endproperty
  a_qual_rearm: assert property (p_qual_rearm) else $error("second pulse without re-arm");

endmodule

//--- logic/rcp_top.sv
// remote on/off, trigger, isolated shutdown and status flags of the supply controller
`timescale 1ns/100ps
`include "rcp_regs.svh"

// Notes on behaviour
// - default polarity: remote input low disables output, high or open enables
// - a control bit inverts the sense of the remote input
// - ignore mode leaves output under enable and disable commands only
// - standby mode: remote low for 100 us disables output, enters standby
// - in standby, remote high does not re-enable; only enable command does
// - reaction to the remote input finishes within 200 ms
// - trigger input low for 100 us gives one event; shorter lows ignored
// - no further trigger until the trigger input returns high
// - a qualified trigger is acted upon within 500 us
// - isolated halt removes output, keeps running, shows fault on indicator
// - isolated halt takes effect within 100 us
// - halt stays latched until power is cycled
// - health flag conducts while operating normally, released otherwise
// - by default off flag conducts while output is off
// - list setup command turns the off flag into a trigger output
// - in list mode the flag level and pulse width follow the setup
// - list clear command returns the off flag to output state
module rcp_top import rcp_pkg::*; #(
  parameter int QUAL_CYC = `RCP_QUAL_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output logic      [31:0] RD_DATA,
  input  wire logic        REMOTE_SWITCH_IN,
  input  wire logic        EVENT_STROBE_IN,
  input  wire logic        ISOLATED_HALT_ANODE,
  output logic             OUTPUT_ENABLE,
  output logic             STANDBY,
  output logic             TRIG_EVENT,
  output logic             HEALTH_INDICATOR,
  output logic             HEALTH_FLAG_COLLECTOR,
  output logic             OFF_FLAG_COLLECTOR,
  output logic             IRQ
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [2:0]  sync_q;
  logic        rem_s;
  logic        trg_s;
  logic        halt_s;
  logic        pin_on;
  logic        rem_fire;
  logic        trg_fire;

  logic        wr_ctrl;
  logic        wr_cmd;
  logic        wr_evt;
  logic        wr_mask;
  logic        wr_tcfg;
  logic        cmd_en;
  logic        cmd_dis;
  logic        cmd_lset;
  logic        cmd_lclr;
  logic        cmd_step;

  rcp_rmode_e  mode;
  rcp_rmode_e  next_mode;
  logic        inv;
  logic        next_inv;
  logic [15:0] width;
  logic [15:0] next_width;
  logic        cond;
  logic        next_cond;
  logic [3:0]  mask;
  logic [3:0]  next_mask;

  rcp_state_e  state;
  rcp_state_e  next_state;
  logic        stby_set;

  logic        list_mode;
  logic        next_list_mode;
  logic [15:0] pulse_cnt;
  logic [15:0] next_pulse_cnt;
  logic        pulse_end;

  logic [3:0]  evt;
  logic [3:0]  next_evt;
  logic [3:0]  evt_set;
  logic        next_trig_event;
  logic [31:0] next_rd_data;

  // ----------------------------------------
  // pin synchronisers and hold qualifiers
  // ----------------------------------------
  // remote and trigger idle high (open), halt idle low
  rcp_sync #(
    .W       (3),
    .RST_VAL (`RCP_SYNC_RST)
  ) u_sync (
    .clk (CLOCK),
    .rst (RST),
    .d   ({ISOLATED_HALT_ANODE, EVENT_STROBE_IN, REMOTE_SWITCH_IN}),
    .q   (sync_q)
  );

  assign rem_s  = sync_q[0];
  assign trg_s  = sync_q[1];
  assign halt_s = sync_q[2];
  assign pin_on = rem_s ^ inv;

  rcp_hold_qual #(
    .LIMIT (QUAL_CYC)
  ) u_rem_qual (
    .clk   (CLOCK),
    .rst   (RST),
    .level (pin_on),
    .fire  (rem_fire)
  );

  rcp_hold_qual #(
    .LIMIT (QUAL_CYC)
  ) u_trg_qual (
    .clk   (CLOCK),
    .rst   (RST),
    .level (trg_s),
    .fire  (trg_fire)
  );

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  assign wr_ctrl  = WR_STB && (ADDR == `RCP_ADDR_CTRL);
  assign wr_cmd   = WR_STB && (ADDR == `RCP_ADDR_CMD);
  assign wr_evt   = WR_STB && (ADDR == `RCP_ADDR_EVT);
  assign wr_mask  = WR_STB && (ADDR == `RCP_ADDR_MASK);
  assign wr_tcfg  = WR_STB && (ADDR == `RCP_ADDR_TRIGCFG);
  assign cmd_en   = wr_cmd && WR_DATA[`RCP_CMD_EN_BIT];
  assign cmd_dis  = wr_cmd && WR_DATA[`RCP_CMD_DIS_BIT];
  assign cmd_lset = wr_cmd && WR_DATA[`RCP_CMD_LSET_BIT];
  assign cmd_lclr = wr_cmd && WR_DATA[`RCP_CMD_LCLR_BIT];
  assign cmd_step = wr_cmd && WR_DATA[`RCP_CMD_STEP_BIT];

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  always_comb begin
    next_mode  = mode;
    next_inv   = inv;
    next_width = width;
    next_cond  = cond;
    next_mask  = mask;
    if (wr_ctrl) begin
      // the unused code 3 falls back to following the pin
      case (WR_DATA[`RCP_CTRL_MODE_LSB +: 2])
        2'h1:    next_mode = RMODE_IGNORE;
        2'h2:    next_mode = RMODE_STANDBY;
        default: next_mode = RMODE_FOLLOW;
      endcase
      next_inv = WR_DATA[`RCP_CTRL_INV_BIT];
    end
    if (wr_tcfg) begin
      next_width = WR_DATA[15:0];
      next_cond  = WR_DATA[`RCP_TCFG_COND_BIT];
    end
    if (wr_mask) begin
      next_mask = WR_DATA[3:0];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      mode  <= RMODE_FOLLOW;
      inv   <= 1'b0;
      width <= `RCP_WIDTH_RST;
      cond  <= 1'b1;
      mask  <= `RCP_MASK_RST;
    end else begin
      mode  <= next_mode;
      inv   <= next_inv;
      width <= next_width;
      cond  <= next_cond;
      mask  <= next_mask;
    end
  end

  // ----------------------------------------
  // output state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    stby_set   = 1'b0;
    case (state)
      ST_HALT: begin
        next_state = ST_HALT;
      end
      ST_ON: begin
        if (cmd_dis) begin
          next_state = ST_OFF;
        end else if (mode == RMODE_STANDBY && rem_fire) begin
          next_state = ST_STANDBY;
          stby_set   = 1'b1;
        end
      end
      ST_OFF: begin
        if (cmd_en) begin
          next_state = ST_ON;
        end
      end
      ST_STANDBY: begin
        if (cmd_en) begin
          next_state = ST_ON;
        end else if (cmd_dis) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
    // halt overrides everything and cannot be left by software
    if (halt_s) begin
      next_state = ST_HALT;
      stby_set   = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= ST_ON;
    end else begin
      state <= next_state;
    end
  end

  // follow mode gates the output by the pin level directly, ignore mode does not look at it
  assign OUTPUT_ENABLE = (state == ST_ON) && (mode != RMODE_FOLLOW || pin_on);
  assign STANDBY       = (state == ST_STANDBY);
  assign HEALTH_INDICATOR      = (state == ST_HALT);
  assign HEALTH_FLAG_COLLECTOR = (state != ST_HALT);

  // ----------------------------------------
  // off flag and list trigger pulse
  // ----------------------------------------
  always_comb begin
    next_list_mode = list_mode;
    next_pulse_cnt = pulse_cnt;
    pulse_end      = 1'b0;
    if (cmd_lclr) begin
      next_list_mode = 1'b0;
      next_pulse_cnt = 16'h0000;
    end else if (cmd_lset) begin
      next_list_mode = 1'b1;
      next_pulse_cnt = 16'h0000;
    end else if (list_mode && cmd_step) begin
      // a zero width still gives a one-cycle pulse
      next_pulse_cnt = (width == 16'h0000) ? 16'h0001 : width;
    end else if (pulse_cnt != 16'h0000) begin
      next_pulse_cnt = pulse_cnt - 16'h0001;
      pulse_end      = (pulse_cnt == 16'h0001);
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      list_mode <= 1'b0;
      pulse_cnt <= 16'h0000;
    end else begin
      list_mode <= next_list_mode;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  assign OFF_FLAG_COLLECTOR = list_mode ? ((pulse_cnt != 16'h0000) ? cond : !cond)
                                        : !OUTPUT_ENABLE;

  // ----------------------------------------
  // events, interrupt, read port
  // ----------------------------------------
  assign evt_set = {pulse_end, (state != ST_HALT) && halt_s, stby_set, trg_fire};

  always_comb begin
    // a set in the cycle of its clear wins
    next_evt        = (evt & ~(wr_evt ? WR_DATA[3:0] : 4'h0)) | evt_set;
    next_trig_event = trg_fire;
    next_rd_data    = 32'h0000_0000;
    if (RD_STB) begin
      case (ADDR)
        `RCP_ADDR_CTRL:    next_rd_data = {29'h0, inv, mode};
        `RCP_ADDR_STATUS:  next_rd_data = {26'h0, trg_s, rem_s, list_mode,
                                           state == ST_HALT, state == ST_STANDBY, OUTPUT_ENABLE};
        `RCP_ADDR_EVT:     next_rd_data = {28'h0, evt};
        `RCP_ADDR_MASK:    next_rd_data = {28'h0, mask};
        `RCP_ADDR_TRIGCFG: next_rd_data = {15'h0, cond, width};
        default:           next_rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      evt        <= 4'h0;
      TRIG_EVENT <= 1'b0;
      RD_DATA    <= 32'h0000_0000;
    end else begin
      evt        <= next_evt;
      TRIG_EVENT <= next_trig_event;
      RD_DATA    <= next_rd_data;
    end
  end

  assign IRQ = |(evt & mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  property p_follow_low;
    (!REMOTE_SWITCH_IN && mode == RMODE_FOLLOW && !inv) [*3] |-> !OUTPUT_ENABLE;
  endproperty
  a_follow_low: assert property (p_follow_low) else $error("output on with remote low");

  property p_invert;
    // pin taken two edges back, so the synchroniser depth is checked as well
    (state == ST_ON && mode == RMODE_FOLLOW && !$past(RST, 2))
      |-> OUTPUT_ENABLE == ($past(REMOTE_SWITCH_IN, 2) ^ inv);
  endproperty
  a_invert: assert property (p_invert) else $error("remote polarity wrong");

  property p_ignore;
    (mode == RMODE_IGNORE && state == ST_ON) |-> OUTPUT_ENABLE;
  endproperty
  a_ignore: assert property (p_ignore) else $error("remote pin not ignored");

  property p_stby_entry;
    (state == ST_ON && mode == RMODE_STANDBY && rem_fire && !cmd_dis && !halt_s)
      |=> STANDBY && !OUTPUT_ENABLE;
  endproperty
  a_stby_entry: assert property (p_stby_entry) else $error("standby not entered");

  property p_stby_hold;
    (state == ST_STANDBY && !cmd_en) |=> !OUTPUT_ENABLE;
  endproperty
  a_stby_hold: assert property (p_stby_hold) else $error("output left standby without command");

  property p_remote_resp;
    ($rose(REMOTE_SWITCH_IN) && mode == RMODE_FOLLOW && !inv && state == ST_ON && !cmd_dis && !halt_s)
      ##1 (REMOTE_SWITCH_IN && mode == RMODE_FOLLOW && !inv && state == ST_ON) [*2] |-> OUTPUT_ENABLE;
  endproperty
  a_remote_resp: assert property (p_remote_resp) else $error("slow remote response");

  property p_trig_resp;
    trg_fire |=> TRIG_EVENT && evt[`RCP_EVT_TRIG_BIT];
  endproperty
  a_trig_resp: assert property (p_trig_resp) else $error("trigger not acted upon");

  property p_halt;
    $rose(ISOLATED_HALT_ANODE) ##1 ISOLATED_HALT_ANODE |-> ##[1:2] (HEALTH_INDICATOR && !OUTPUT_ENABLE);
  endproperty
  a_halt: assert property (p_halt) else $error("halt too slow");

  property p_halt_latch;
    HEALTH_INDICATOR |=> HEALTH_INDICATOR && !OUTPUT_ENABLE && !HEALTH_FLAG_COLLECTOR;
  endproperty
  a_halt_latch: assert property (p_halt_latch) else $error("halt released");

  property p_off_flag;
    !list_mode |-> OFF_FLAG_COLLECTOR == !OUTPUT_ENABLE;
  endproperty
  a_off_flag: assert property (p_off_flag) else $error("off flag wrong");

  property p_list_pulse;
    (list_mode && cmd_step && !cmd_lclr && !cmd_lset && width == 16'h0003)
      |=> (OFF_FLAG_COLLECTOR == cond) [*3] ##1 (OFF_FLAG_COLLECTOR != cond || !list_mode);
  endproperty
  a_list_pulse: assert property (p_list_pulse) else $error("list pulse shape wrong");

  property p_list_clear;
    cmd_lclr |=> !list_mode && OFF_FLAG_COLLECTOR == !OUTPUT_ENABLE;
  endproperty
  a_list_clear: assert property (p_list_clear) else $error("list clear ignored");

  c_standby: cover property (state == ST_ON ##1 STANDBY);
  c_trigger: cover property (trg_fire);
  c_halt:    cover property (!HEALTH_INDICATOR ##1 HEALTH_INDICATOR);
  c_pulse:   cover property (pulse_end && list_mode);

endmodule

//--- sim/rcp_equip.sv
// model of the external test equipment on the trigger and protect connectors
`timescale 1ns/100ps

module rcp_equip (
  input  wire logic       clock,
  input  wire logic       trig_event,
  output logic            remote_switch_in,
  output logic            event_strobe_in,
  output logic            isolated_halt_anode,
  output logic [7:0]      trig_count
);
  // ----------------------------------------
  // idle levels: remote open, trigger armed, halt off
  // ----------------------------------------
  initial begin
    remote_switch_in    = 1'b1;
    event_strobe_in     = 1'b1;
    isolated_halt_anode = 1'b0;
    trig_count          = 8'h00;
  end

  // ----------------------------------------
  // counts trigger events seen by the equipment
  // ----------------------------------------
  always @(posedge clock) begin
    if (trig_event === 1'b1) begin
      trig_count <= trig_count + 8'h01;
    end
  end

  // pins move just after an edge, like a real contact
  task automatic set_pin(input int pin, input logic v);
    @(posedge clock);
    case (pin)
      0: remote_switch_in <= v;
      1: event_strobe_in <= v;
      default: isolated_halt_anode <= v;
    endcase
  endtask
endmodule

//--- sim/rcp_top_tb.sv
// self-checking testbench of the remote control and protect block
`timescale 1ns/100ps
`include "rcp_regs.svh"

module rcp_top_tb;
  localparam int QUAL = 8;
  logic        clock;
  logic        rst;
  logic [3:0]  addr;
  logic [31:0] wr_data;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rd_data;
  logic        remote_pin;
  logic        strobe_pin;
  logic        halt_pin;
  logic        oe;
  logic        stby;
  logic        trig_ev;
  logic        health_ind;
  logic        health_flag;
  logic        off_flag;
  logic        irq;
  logic [7:0]  trig_count;
  logic [31:0] rv;
  int          num_errors;
  int          tests_run;
  int          hi_cnt;
  logic [7:0]  base;

  // ----------------------------------------
  // clock, instances
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  rcp_top #(.QUAL_CYC(QUAL)) u_dut (
    .CLOCK(clock), .RST(rst), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RD_DATA(rd_data), .REMOTE_SWITCH_IN(remote_pin),
    .EVENT_STROBE_IN(strobe_pin), .ISOLATED_HALT_ANODE(halt_pin), .OUTPUT_ENABLE(oe),
    .STANDBY(stby), .TRIG_EVENT(trig_ev), .HEALTH_INDICATOR(health_ind),
    .HEALTH_FLAG_COLLECTOR(health_flag), .OFF_FLAG_COLLECTOR(off_flag), .IRQ(irq));

  rcp_equip u_equip (
    .clock(clock), .trig_event(trig_ev), .remote_switch_in(remote_pin),
    .event_strobe_in(strobe_pin), .isolated_halt_anode(halt_pin), .trig_count(trig_count));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge clock);
    wr_stb  <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    rv = rd_data;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wr_data = 32'h0000_0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    num_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    wait_cyc(3);
    check("oe", oe, 32'h1);
    check("health flag", health_flag, 32'h1);
    check("off flag", off_flag, 32'h0);
    rd(`RCP_ADDR_TRIGCFG); check("trigcfg", rv, 32'h0001_00C8);
    wait_cyc(1); check("rd idle", rd_data, 32'h0);
    rd(4'hF); check("unmapped", rv, 32'h0);
    // follow mode, default then inverted sense
    u_equip.set_pin(0, 1'b0);
    wait_cyc(1); check("oe sync", oe, 32'h1);
    wait_cyc(3); check("oe low", oe, 32'h0);
    check("off flag", off_flag, 32'h1);
    wr(`RCP_ADDR_CTRL, 32'h4);
    wait_cyc(4); check("oe inv", oe, 32'h1);
    u_equip.set_pin(0, 1'b1);
    wait_cyc(4); check("oe inv hi", oe, 32'h0);
    // ignore mode: commands only
    wr(`RCP_ADDR_CTRL, 32'h1);
    u_equip.set_pin(0, 1'b0);
    wait_cyc(6); check("oe ign", oe, 32'h1);
    wr(`RCP_ADDR_CMD, 32'h2);
    wait_cyc(2); check("oe dis", oe, 32'h0);
    wr(`RCP_ADDR_CMD, 32'h1);
    wait_cyc(2); check("oe en", oe, 32'h1);
    // standby mode
    u_equip.set_pin(0, 1'b1);
    wr(`RCP_ADDR_CTRL, 32'h2);
    wr(`RCP_ADDR_MASK, 32'h2);
    u_equip.set_pin(0, 1'b0);
    wait_cyc(QUAL - 4);
    u_equip.set_pin(0, 1'b1);
    wait_cyc(QUAL + 6); check("stby short", stby, 32'h0);
    u_equip.set_pin(0, 1'b0);
    wait_cyc(QUAL + 6); check("stby", stby, 32'h1);
    check("oe stby", oe, 32'h0);
    check("irq", irq, 32'h1);
    u_equip.set_pin(0, 1'b1);
    wait_cyc(6); check("oe stays off", oe, 32'h0);
    wr(`RCP_ADDR_EVT, 32'h2);
    wait_cyc(1); check("irq clr", irq, 32'h0);
    wr(`RCP_ADDR_CMD, 32'h1);
    wait_cyc(2); check("oe back", oe, 32'h1);
    // trigger: short low ignored, one event per long low, masked irq
    // unused mode code falls back to follow, non-inverted
    wr(`RCP_ADDR_CTRL, 32'h3);
    rd(`RCP_ADDR_CTRL); check("mode 3", rv, 32'h0);
    base = trig_count;
    u_equip.set_pin(1, 1'b0);
    wait_cyc(QUAL - 4);
    u_equip.set_pin(1, 1'b1);
    wait_cyc(QUAL + 6); check("trig short", trig_count, base);
    u_equip.set_pin(1, 1'b0);
    wait_cyc(QUAL + 5); check("trig one", trig_count, base + 8'h1);
    wait_cyc(3 * QUAL); check("trig held", trig_count, base + 8'h1);
    check("irq masked", irq, 32'h0);
    u_equip.set_pin(1, 1'b1);
    wait_cyc(4);
    u_equip.set_pin(1, 1'b0);
    wait_cyc(QUAL + 5); check("trig rearm", trig_count, base + 8'h2);
    u_equip.set_pin(1, 1'b1);
    wr(`RCP_ADDR_MASK, 32'h1);
    wait_cyc(1); check("irq trig", irq, 32'h1);
    wr(`RCP_ADDR_EVT, 32'hF);
    wr(`RCP_ADDR_MASK, 32'h0);
    // list mode: flag repurposed, pulse level and width from setup
    wr(`RCP_ADDR_CMD, 32'h2);
    for (int k = 0; k < 2; k++) begin
      wr(`RCP_ADDR_TRIGCFG, k == 0 ? 32'h0001_0003 : 32'h0000_0005);
      wr(`RCP_ADDR_CMD, 32'h4);
      wait_cyc(1); check("idle", off_flag, k);
      wr(`RCP_ADDR_CMD, 32'h10);
      hi_cnt = 0;
      #1;
      repeat (12) begin
        if (off_flag === (k == 0)) hi_cnt++;
        @(posedge clock);
        #1;
      end
      check("width", hi_cnt, k == 0 ? 3 : 5);
      rd(`RCP_ADDR_EVT); check("evt end", rv[3], 32'h1);
      wr(`RCP_ADDR_EVT, 32'h8);
    end
    wr(`RCP_ADDR_CMD, 32'h8);
    wait_cyc(2); check("off restored", off_flag, 32'h1);
    wr(`RCP_ADDR_CMD, 32'h1);
    // isolated halt latches until reset
    u_equip.set_pin(2, 1'b1);
    wait_cyc(5); check("halt oe", oe, 32'h0);
    check("halt ind", health_ind, 32'h1);
    check("halt pg", health_flag, 32'h0);
    u_equip.set_pin(2, 1'b0);
    wr(`RCP_ADDR_CMD, 32'h1);
    wait_cyc(5); check("latched", oe, 32'h0);
    rd(`RCP_ADDR_STATUS); check("halted", rv[2], 32'h1);
    check("status", rv, 32'h0000_0034);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    wait_cyc(4); check("power cycle", oe, 32'h1);
    check("ind ok", health_ind, 32'h0);
    stop_test();
  end
endmodule
